// file: rtl/timer16_counter_byte_access.sv
// Sixteen-bit timer core with shared high-byte latch, reached over classic Wishbone.
// Assumes an 8-bit data path in the low lanes, a prescaler producing single-cycle strobes on clk_i,
// and an external event pin that is asynchronous to clk_i.
// Functional notes
// R1 - Sixteen-bit registers are reached only as two separate byte transfers.
// R2 - One shared eight-bit high-byte latch serves every sixteen-bit register.
// R3 - Low-byte write loads latch plus written byte into register in one cycle.
// R4 - Low-byte read copies high half into latch; high-byte read returns latch.
// R5 - Compare register reads bypass the latch and leave it unchanged.
// R6 - Software writes the high byte before the low byte.
// R7 - Software reads the low byte before the high byte.
// R8 - Main code disables interrupts across both halves when interrupts share latch.
// R9 - A shared high byte may be written once, then several low bytes.
// R10 - Three-bit clock select picks tick source; zero halts the counter.
// R11 - Counter is readable and writable whether or not ticks arrive.
// R12 - A software counter write beats clear, increment or decrement.
// R13 - Each tick clears, increments or decrements the counter per mode.
// R14 - Steps are exactly one, direction chooses sign, clear zeroes all bits.
// R15 - TOP shows at sequence maximum, BOTTOM shows at zero.
// R16 - Counter is two byte locations; high location only touches the latch.
// R17 - Waveform mode field, split over control A and B, picks the sequence.
// R18 - Overflow flag set at mode-defined point and requests an interrupt.
// R19 - BOTTOM is 0x0000 and absolute maximum is 0xFFFF.
// R20 - Software clears the power-off bit before using the timer.
// R21 - The tick is a single-cycle enable inside the system clock domain.
`include "timer16_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module timer16_counter_byte_access (
	input wire logic clk_i, // System clock, 125 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic [5:0] adr_i, // Wishbone byte address
	input wire logic [31:0] dat_i, // Wishbone write data
	output logic [31:0] dat_o, // Wishbone read data
	input wire logic we_i, // Wishbone write enable
	input wire logic [3:0] sel_i, // Wishbone byte selects
	input wire logic cyc_i, // Wishbone cycle
	input wire logic stb_i, // Wishbone strobe
	output logic ack_o, // Wishbone acknowledge
	input wire logic power_off_i, // Timer power-off bit, high disables
	input wire logic [4:0] presc_tick_i, // Prescaler strobes: /1 /8 /64 /256 /1024
	input wire logic ext_pin_i, // External tick pin, asynchronous
	input wire logic capture_i, // Capture strobe from capture unit
	output logic [15:0] count_o, // Current counter value
	output logic top_o, // Counter at sequence maximum
	output logic bottom_o, // Counter at zero
	output logic overflow_irq_o // Overflow interrupt request
);
	import timer16_pkg::*;

	byte_t ctrl_a_r, ctrl_a_nxt, ctrl_b_r, ctrl_b_nxt, latch_r, latch_nxt;
	word_t count_r, count_nxt, cmp_a_r, cmp_a_nxt, cmp_b_r, cmp_b_nxt, capt_r, capt_nxt;
	logic dir_down_r, dir_down_nxt, ovf_r, ovf_nxt, ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic ext_s1_r, ext_s2_r, ext_s3_r;
	logic top_r, bottom_r, top_nxt, bottom_nxt;
	logic tick, wr, rd, ovf_evt, clr, at_top, at_bot;
	logic [3:0] wgm;
	word_t top_val;
	clk_sel_t cs;

	function automatic word_t join_latch(input byte_t hi, input byte_t lo);
		return {hi, lo};
	endfunction

	// Pin synchroniser; third stage only for edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_pin_i;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end

	assign cs = clk_sel_t'(ctrl_b_r[`CTRL_B_CS_HI:0]);
	assign wgm = {ctrl_b_r[`CTRL_B_WGM_MSB:`CTRL_B_WGM_LSB], ctrl_a_r[`CTRL_A_WGM_LO:0]}; // R17

	// Tick is a one-cycle enable, never a clock
	always_comb begin
		unique case (cs) // R10 R21
			CS_STOP: tick = 1'b0;
			CS_DIV1: tick = presc_tick_i[0];
			CS_DIV8: tick = presc_tick_i[1];
			CS_DIV64: tick = presc_tick_i[2];
			CS_DIV256: tick = presc_tick_i[3];
			CS_DIV1024: tick = presc_tick_i[4];
			CS_EXT_FALL: tick = ext_s3_r & ~ext_s2_r;
			CS_EXT_RISE: tick = ~ext_s3_r & ext_s2_r;
		endcase
		// Power-off beats every source; the bus keeps working
		if (power_off_i)
			tick = 1'b0;
	end

	// Simplified mode set: fixed tops, compare A/capture tops, phase correct counts both ways
	always_comb begin
		unique case (wgm[1:0])
			2'b01: top_val = `TOP_8BIT;
			2'b10: top_val = `TOP_9BIT;
			2'b11: top_val = `TOP_10BIT;
			default: top_val = wgm[3] ? capt_r : (wgm[2] ? cmp_a_r : `COUNT_MAX);
		endcase
		if (wgm == 4'hA || wgm == 4'hC || wgm == 4'hE)
			top_val = capt_r;
		else if (wgm == 4'hF || wgm == 4'hB || wgm == 4'h9)
			top_val = cmp_a_r;
	end

	assign at_top = (count_r == top_val); // R15
	assign at_bot = (count_r == `COUNT_BOTTOM); // R15 R19
	assign wr = cyc_i & stb_i & we_i & sel_i[0] & ~ack_r;
	assign rd = cyc_i & stb_i & ~we_i & ~ack_r;

	always_comb begin
		logic phase_correct;
		logic wr_hit_count;
		phase_correct = (wgm[3:2] == 2'b00 || wgm == 4'h8 || wgm == 4'h9 || wgm == 4'hA || wgm == 4'hB)
			&& wgm != 4'h0 && wgm != 4'h4;
		wr_hit_count = 1'b0;
		ctrl_a_nxt = ctrl_a_r;
		ctrl_b_nxt = ctrl_b_r;
		latch_nxt = latch_r;
		count_nxt = count_r;
		cmp_a_nxt = cmp_a_r;
		cmp_b_nxt = cmp_b_r;
		capt_nxt = capture_i ? count_r : capt_r;
		dir_down_nxt = dir_down_r;
		ovf_evt = 1'b0;
		clr = 1'b0;
		ack_nxt = cyc_i & stb_i & ~ack_r;
		dat_nxt = 32'h0000_0000;
		// Counting path
		if (tick) begin // R11 R13
			if (phase_correct) begin
				if (!dir_down_r && at_top)
					dir_down_nxt = 1'b1;
				else if (dir_down_r && at_bot) begin
					dir_down_nxt = 1'b0;
					ovf_evt = 1'b1;
				end
				count_nxt = (dir_down_nxt ? count_r - 16'h0001 : count_r + 16'h0001); // R14
			end else begin
				dir_down_nxt = 1'b0;
				clr = at_top;
				ovf_evt = at_top && (wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hC) ? (count_r == `COUNT_MAX) : at_top;
				count_nxt = clr ? `COUNT_BOTTOM : count_r + 16'h0001; // R14
			end
		end
		// Byte-wide accesses; high locations only touch the latch, except compare-high reads, which return the register
		if (wr) begin // R1 R16
			unique case (adr_i)
				`OFF_CTRL_A: ctrl_a_nxt = dat_i[7:0];
				`OFF_CTRL_B: ctrl_b_nxt = dat_i[7:0];
				`OFF_COUNT_HIGH, `OFF_CMP_A_HIGH, `OFF_CMP_B_HIGH, `OFF_CAPT_HIGH, `OFF_LATCH:
					latch_nxt = dat_i[7:0]; // R2 R16
				`OFF_COUNT_LOW: begin
					count_nxt = join_latch(latch_r, dat_i[7:0]); // R3 R12
					wr_hit_count = 1'b1;
				end
				`OFF_CMP_A_LOW: cmp_a_nxt = join_latch(latch_r, dat_i[7:0]); // R3
				`OFF_CMP_B_LOW: cmp_b_nxt = join_latch(latch_r, dat_i[7:0]); // R3
				`OFF_CAPT_LOW: capt_nxt = join_latch(latch_r, dat_i[7:0]); // R3
				`OFF_STATUS: ovf_evt = ovf_evt;
				default: ;
			endcase
		end
		if (rd) begin
			unique case (adr_i)
				`OFF_CTRL_A: dat_nxt[7:0] = ctrl_a_r;
				`OFF_CTRL_B: dat_nxt[7:0] = ctrl_b_r;
				`OFF_COUNT_LOW: begin
					dat_nxt[7:0] = count_r[7:0];
					latch_nxt = count_r[15:8]; // R4
				end
				`OFF_CAPT_LOW: begin
					dat_nxt[7:0] = capt_r[7:0];
					latch_nxt = capt_r[15:8]; // R4
				end
				`OFF_CMP_A_LOW: dat_nxt[7:0] = cmp_a_r[7:0]; // R5
				`OFF_CMP_A_HIGH: dat_nxt[7:0] = cmp_a_r[15:8]; // R5
				`OFF_CMP_B_LOW: dat_nxt[7:0] = cmp_b_r[7:0]; // R5
				`OFF_CMP_B_HIGH: dat_nxt[7:0] = cmp_b_r[15:8]; // R5
				`OFF_COUNT_HIGH, `OFF_CAPT_HIGH, `OFF_LATCH: dat_nxt[7:0] = latch_r; // R4 R16
				`OFF_STATUS: dat_nxt[2:0] = {bottom_r, top_r, ovf_r};
				default: ;
			endcase
		end
		// A counter write keeps the sweep direction; only ticks turn it
		if (wr_hit_count)
			dir_down_nxt = dir_down_r;
		// Set beats a simultaneous write-one clear
		ovf_nxt = ovf_r;
		if (wr && adr_i == `OFF_STATUS && dat_i[`STAT_OVF])
			ovf_nxt = 1'b0;
		if (ovf_evt)
			ovf_nxt = 1'b1; // R18
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_a_r <= `CTRL_RESET;
			ctrl_b_r <= `CTRL_RESET;
			latch_r <= 8'h00;
			count_r <= `COUNT_BOTTOM;
			cmp_a_r <= 16'h0000;
			cmp_b_r <= 16'h0000;
			capt_r <= 16'h0000;
			dir_down_r <= 1'b0;
			ovf_r <= 1'b0;
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ctrl_a_r <= ctrl_a_nxt;
			ctrl_b_r <= ctrl_b_nxt;
			latch_r <= latch_nxt;
			count_r <= count_nxt;
			cmp_a_r <= cmp_a_nxt;
			cmp_b_r <= cmp_b_nxt;
			capt_r <= capt_nxt;
			dir_down_r <= dir_down_nxt;
			ovf_r <= ovf_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	// Flags follow the next count so they line up with count_o
	always_comb begin
		top_nxt = (count_nxt == top_val); // R15
		bottom_nxt = (count_nxt == `COUNT_BOTTOM); // R15 R19
	end

	// Status outputs registered so ports come straight from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			top_r <= 1'b0;
			bottom_r <= 1'b1;
		end else begin
			top_r <= top_nxt;
			bottom_r <= bottom_nxt;
		end
	end

	assign dat_o = dat_r;
	assign ack_o = ack_r;
	assign count_o = count_r;
	assign top_o = top_r;
	assign bottom_o = bottom_r;
	assign overflow_irq_o = ovf_r;

	// Handshake, byte path and counting checks
	a_low_write_load: assert property (@(posedge clk_i) disable iff (rst_i) // R3 R12
		wr && adr_i == `OFF_COUNT_LOW |=> count_r == {$past(latch_r), $past(dat_i[7:0])})
		else $error("count low write did not load latch and byte");
	a_low_read_latch: assert property (@(posedge clk_i) disable iff (rst_i) // R4
		rd && adr_i == `OFF_COUNT_LOW |=> latch_r == $past(count_r[15:8]))
		else $error("count low read did not copy high half");
	a_capt_read_latch: assert property (@(posedge clk_i) disable iff (rst_i) // R4
		rd && adr_i == `OFF_CAPT_LOW |=> latch_r == $past(capt_r[15:8]))
		else $error("capture low read did not copy high half");
	a_cmp_read_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // R5
		rd && (adr_i == `OFF_CMP_A_LOW || adr_i == `OFF_CMP_B_HIGH) |=> $stable(latch_r))
		else $error("compare read disturbed latch");
	a_stop_holds: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		(cs == CS_STOP) && !wr |=> $stable(count_r))
		else $error("counter moved with no clock source");
	a_power_freeze: assert property (@(posedge clk_i) disable iff (rst_i) // R20
		power_off_i && !wr |=> $stable(count_r))
		else $error("counter moved while powered off");
	a_step_one: assert property (@(posedge clk_i) disable iff (rst_i) // R13 R14
		tick && !wr && !clr && !at_top && !at_bot |=> (count_r == $past(count_r) + 16'h0001)
			|| (count_r == $past(count_r) - 16'h0001))
		else $error("count step not one");
	a_high_to_latch: assert property (@(posedge clk_i) disable iff (rst_i) // R16 R2
		wr && adr_i == `OFF_COUNT_HIGH && !tick |=> latch_r == $past(dat_i[7:0]) && $stable(count_r))
		else $error("high write reached the counter");
	a_masked_write: assert property (@(posedge clk_i) disable iff (rst_i) // R2
		cyc_i && stb_i && we_i && !sel_i[0] && !ack_o |=> $stable(latch_r) && $stable(ctrl_b_r))
		else $error("write with low lane off took effect");
	a_bottom_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R15 R19
		bottom_o == (count_r == `COUNT_BOTTOM))
		else $error("bottom indication wrong");
	a_top_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R15
		top_o == (count_r == $past(top_val)))
		else $error("top indication wrong");
	a_ovf_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // R18
		ovf_evt |=> ovf_r ##0 overflow_irq_o)
		else $error("overflow event lost");
	a_ovf_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R18
		wr && adr_i == `OFF_STATUS && dat_i[`STAT_OVF] && !ovf_evt |=> !ovf_r)
		else $error("overflow flag not cleared");
	a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		ack_o |=> !ack_o)
		else $error("acknowledge held longer than one cycle");
	a_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		!ack_o |-> dat_o == 32'h0000_0000)
		else $error("read data showing outside an answer");
endmodule

`default_nettype wire

// file: rtl/timer16_regs.svh
// Register offsets, field positions and reset values for the byte-wide 16-bit timer.
// Included by the design and the bench; definitions only.
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// Word offsets on the Wishbone bus (byte address = 4 * index)
`define OFF_CTRL_A 6'h00
`define OFF_CTRL_B 6'h04
`define OFF_COUNT_LOW 6'h08
`define OFF_COUNT_HIGH 6'h0C
`define OFF_CMP_A_LOW 6'h10
`define OFF_CMP_A_HIGH 6'h14
`define OFF_CMP_B_LOW 6'h18
`define OFF_CMP_B_HIGH 6'h1C
`define OFF_CAPT_LOW 6'h20
`define OFF_CAPT_HIGH 6'h24
`define OFF_STATUS 6'h28
`define OFF_LATCH 6'h2C

// Control A: waveform mode bits 1:0 at [1:0]
`define CTRL_A_WGM_LO 1
// Control B: clock select [2:0], waveform mode bits 3:2 at [4:3]
`define CTRL_B_CS_HI 2
`define CTRL_B_WGM_LSB 3
`define CTRL_B_WGM_MSB 4
// Status: overflow flag bit 0 (write one clears), top bit 1, bottom bit 2
`define STAT_OVF 0
`define STAT_TOP 1
`define STAT_BOT 2

`define CTRL_RESET 8'h00
`define COUNT_BOTTOM 16'h0000
`define COUNT_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF

`endif

// file: rtl/timer16_pkg.sv
// Types shared by the byte-wide 16-bit timer.
// Assumes the constants header sits beside it.
package timer16_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] word_t;
	typedef enum logic [2:0] {
		CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
	} clk_sel_t;
endpackage

// file: bench/cpu_bus_model.sv
// CPU-side model: byte transfers over classic Wishbone.
// Assumes the slave acks every request.
`timescale 1ns/100ps
`default_nettype none

module cpu_bus_model (
	input wire logic clk_i, // Bus clock
	input wire logic ack_i, // Slave ack
	input wire logic [31:0] rdat_i, // Read data
	output var logic [5:0] adr_o, // Address
	output var logic [3:0] sel_o, // Byte selects
	output var logic [31:0] wdat_o, // Write data
	output var logic we_o, // Write enable
	output var logic cyc_o, // Cycle
	output var logic stb_o // Strobe
);
	initial begin
		adr_o = 6'h00;
		sel_o = 4'h0;
		wdat_o = 32'h0;
		we_o = 1'b0;
		cyc_o = 1'b0;
		stb_o = 1'b0;
	end
	task automatic xfer_sel(input logic [5:0] a, input logic [3:0] s, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		adr_o <= a;
		sel_o <= s;
		we_o <= w;
		wdat_o <= {24'h000000, d};
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = rdat_i[7:0];
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
	endtask
	task automatic xfer(input logic [5:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		xfer_sel(a, 4'h1, w, d, q);
	endtask
	// Both halves back to back, nothing else in between
	task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
		logic [7:0] q;
		xfer(lo + 6'h04, 1'b1, v[15:8], q);
		xfer(lo, 1'b1, v[7:0], q);
	endtask
	task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
		xfer(lo, 1'b0, 8'h00, v[7:0]);
		xfer(lo + 6'h04, 1'b0, 8'h00, v[15:8]);
	endtask
endmodule
`default_nettype wire

// file: bench/timer16_counter_byte_access_bench.sv
// Bench for the byte-wide 16-bit timer.
// Assumes one-cycle bus answers and single-cycle tick strobes.
`include "timer16_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module timer16_counter_byte_access_bench;
	logic clk_i, rst_i, pwr_off, ext_pin, capt;
	logic [4:0] presc;
	logic [5:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic we, cyc, stb, ack, top, bot, ovf;
	logic [15:0] cnt, v;
	logic [7:0] b;
	int err_count, n_checks, cycles;

	timer16_counter_byte_access timer16_counter_byte_access_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
		.dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
		.power_off_i(pwr_off), .presc_tick_i(presc), .ext_pin_i(ext_pin), .capture_i(capt), .count_o(cnt),
		.top_o(top), .bottom_o(bot), .overflow_irq_o(ovf));
	cpu_bus_model cpu_bus_model_i (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .adr_o(adr), .sel_o(sel), .wdat_o(wdat),
		.we_o(we), .cyc_o(cyc), .stb_o(stb));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Scenarios need well under a thousand cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			summarize();
		end
	end
	task automatic pulse(input logic [4:0] m);
		@(posedge clk_i);
		presc <= m;
		@(posedge clk_i);
		presc <= 5'h00;
		@(negedge clk_i);
	endtask
	task automatic t_bytes;
		cpu_bus_model_i.wr16(`OFF_COUNT_LOW, 16'h01FF);
		@(negedge clk_i);
		chk(cnt, 16'h01FF);
		cpu_bus_model_i.wr16(`OFF_CMP_A_LOW, 16'hABCD);
		cpu_bus_model_i.xfer(`OFF_COUNT_LOW, 1'b0, 8'h00, b);
		chk({8'h00, b}, 16'h00FF);
		cpu_bus_model_i.rd16(`OFF_CMP_A_LOW, v);
		chk(v, 16'hABCD);
		cpu_bus_model_i.xfer(`OFF_COUNT_HIGH, 1'b0, 8'h00, b);
		chk({8'h00, b}, 16'h0001);
		// One high byte serves two low writes
		cpu_bus_model_i.xfer(`OFF_COUNT_HIGH, 1'b1, 8'h12, b);
		cpu_bus_model_i.xfer(`OFF_CMP_B_LOW, 1'b1, 8'h34, b);
		cpu_bus_model_i.xfer(`OFF_COUNT_LOW, 1'b1, 8'h56, b);
		cpu_bus_model_i.rd16(`OFF_CMP_B_LOW, v);
		chk(v, 16'h1234);
		capt <= 1'b1;
		@(posedge clk_i);
		capt <= 1'b0;
		cpu_bus_model_i.rd16(`OFF_CAPT_LOW, v);
		chk(v, 16'h1256);
		cpu_bus_model_i.xfer(6'h30, 1'b0, 8'h00, b);
		chk({8'h00, b}, 16'h0000);
	endtask
	task automatic t_ticks;
		cpu_bus_model_i.wr16(`OFF_COUNT_LOW, 16'hFFFE);
		cpu_bus_model_i.xfer(`OFF_CTRL_B, 1'b1, 8'h01, b);
		pulse(5'h01);
		@(negedge clk_i);
		chk(cnt, 16'hFFFF);
		chk({14'h0, top, bot}, 16'h0002);
		pulse(5'h01);
		@(negedge clk_i);
		chk(cnt, 16'h0000);
		chk({13'h0, top, bot, ovf}, 16'h0003);
		for (int cs = 1; cs < 6; cs++) begin
			cpu_bus_model_i.xfer(`OFF_CTRL_B, 1'b1, 8'(cs), b);
			pulse(5'h1F ^ 5'(1 << (cs - 1)));
			pulse(5'(1 << (cs - 1)));
			chk(cnt, 16'(cs));
		end
		cpu_bus_model_i.xfer(`OFF_CTRL_B, 1'b1, 8'h00, b);
		pulse(5'h1F);
		chk(cnt, 16'h0005);
		cpu_bus_model_i.xfer(`OFF_CTRL_B, 1'b1, 8'h07, b);
		ext_pin <= 1'b1;
		repeat (6) @(negedge clk_i);
		chk(cnt, 16'h0006);
		@(posedge clk_i);
		ext_pin <= 1'b0;
		repeat (6) @(negedge clk_i);
		chk(cnt, 16'h0006);
		cpu_bus_model_i.xfer(`OFF_CTRL_B, 1'b1, 8'h06, b);
		ext_pin <= 1'b1;
		repeat (6) @(negedge clk_i);
		chk(cnt, 16'h0006);
		@(posedge clk_i);
		ext_pin <= 1'b0;
		repeat (6) @(negedge clk_i);
		chk(cnt, 16'h0007);
	endtask
	// Tick held every cycle while the low byte is written
	task automatic t_prio;
		cpu_bus_model_i.xfer(`OFF_CTRL_B, 1'b1, 8'h01, b);
		presc <= 5'h01;
		cpu_bus_model_i.wr16(`OFF_COUNT_LOW, 16'h1000);
		@(negedge clk_i);
		chk(cnt, 16'h1001);
		@(posedge clk_i);
		presc <= 5'h00;
	endtask
	// Status flag, power-off, masked lane, then compare-top and up-down sequences
	task automatic t_modes;
		cpu_bus_model_i.wr16(`OFF_COUNT_LOW, 16'h0010);
		cpu_bus_model_i.xfer(`OFF_STATUS, 1'b0, 8'h00, b);
		chk({8'h00, b}, 16'h0001);
		cpu_bus_model_i.xfer(`OFF_STATUS, 1'b1, 8'h01, b);
		chk({15'h0000, ovf}, 16'h0000);
		pwr_off <= 1'b1;
		pulse(5'h01);
		chk(cnt, 16'h0010);
		@(posedge clk_i);
		pwr_off <= 1'b0;
		cpu_bus_model_i.xfer_sel(`OFF_LATCH, 4'h0, 1'b1, 8'h77, b);
		cpu_bus_model_i.xfer(`OFF_LATCH, 1'b0, 8'h00, b);
		chk({8'h00, b}, 16'h0000);
		cpu_bus_model_i.wr16(`OFF_CMP_A_LOW, 16'h0003);
		cpu_bus_model_i.wr16(`OFF_COUNT_LOW, 16'h0000);
		cpu_bus_model_i.xfer(`OFF_CTRL_B, 1'b1, 8'h09, b);
		repeat (3) pulse(5'h01);
		chk(cnt, 16'h0003);
		chk({15'h0000, top}, 16'h0001);
		pulse(5'h01);
		chk(cnt, 16'h0000);
		chk({13'h0000, top, bot, ovf}, 16'h0002);
		cpu_bus_model_i.xfer(`OFF_CTRL_B, 1'b1, 8'h01, b);
		cpu_bus_model_i.wr16(`OFF_COUNT_LOW, 16'h00FE);
		cpu_bus_model_i.xfer(`OFF_CTRL_A, 1'b1, 8'h01, b);
		pulse(5'h01);
		chk(cnt, 16'h00FF);
		chk({15'h0000, top}, 16'h0001);
		pulse(5'h01);
		chk(cnt, 16'h00FE);
		cpu_bus_model_i.wr16(`OFF_COUNT_LOW, 16'h0001);
		pulse(5'h01);
		chk(cnt, 16'h0000);
		pulse(5'h01);
		chk(cnt, 16'h0001);
		chk({15'h0000, ovf}, 16'h0001);
		cpu_bus_model_i.xfer(`OFF_CTRL_A, 1'b1, 8'h00, b);
		cpu_bus_model_i.xfer(`OFF_CTRL_B, 1'b1, 8'h00, b);
	endtask
	initial begin
		rst_i = 1'b1;
		pwr_off = 1'b0;
		ext_pin = 1'b0;
		capt = 1'b0;
		presc = 5'h00;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({13'h0, top, bot, ovf}, 16'h0002);
		chk(cnt, 16'h0000);
		t_bytes();
		t_ticks();
		t_prio();
		t_modes();
		summarize();
	end
endmodule
`default_nettype wire
